// File: pkg/stint_defines.svh
// register indices, field positions, reset values and timing counts
// assumes a 32-bit apb slave in which register index n sits at byte 4*n
`ifndef STINT_DEFINES_SVH
`define STINT_DEFINES_SVH

// register indices, byte address is four times the index
`define STINT_IDX_DRIVER_CONF 6'h05
`define STINT_IDX_CHOP_CONF 6'h06
`define STINT_IDX_CURRENT 6'h07
`define STINT_IDX_STATUS 6'h08
`define STINT_IDX_TUNE 6'h09
`define STINT_IDX_PRESET 6'h0A

// reset values
`define STINT_DRIVER_CONF_RST 32'h00000077
`define STINT_CHOP_CONF_RST 32'h00000000
`define STINT_CURRENT_RST 32'h00001F08

// chopper configuration fields
`define STINT_CHOP_INTPOL 0
`define STINT_CHOP_DEDGE 1
`define STINT_CHOP_MRES_LSB 4
`define STINT_CHOP_AT_EN 8
`define STINT_CHOP_HOLD_EN 9

// current fields, 5 bits each
`define STINT_CUR_HOLD_LSB 0
`define STINT_CUR_RUN_LSB 8

// driver configuration fields
`define STINT_DRV_TMO_LSB 0
`define STINT_DRV_TMO_STRIDE 4
`define STINT_DRV_RANGE_LSB 8
`define STINT_DRV_RANGE_W 3
`define STINT_DRV_GSCALE_LSB 24

// timing: period and AT1 in system clock cycles, AT2 in microsteps, then the microstep shift limit
`define STINT_PERIOD_MAX (2**20)
`define STINT_AT1_CLKS ((2**20) + 2 * (2**18))
`define STINT_AT2_MSTEPS 12'h800
`define STINT_MSTEP_SHIFT_MAX 4'h8

`endif

// File: pkg/stint_pkg.sv
// types shared by the step interpolator and tuning sequencer
// assumes stint_defines.svh carries the numeric constants
package stint_pkg;

  // feedback from the current regulator, same clock
  typedef struct packed {
    logic [9:0] summed_pwm_scale;
    logic correction_up;
    logic correction_down;
  } stint_fb_t;

  // per-motor results towards sequencer and chopper
  typedef struct packed {
    logic [9:0] mstep_pos;
    logic mstep_pulse;
    logic standstill;
    logic [4:0] current_scale;
    logic [7:0] tuned_pwm_offset;
    logic [7:0] tuned_pwm_gradient;
    logic tune_valid;
  } stint_mout_t;

  // tuning sequencer states
  typedef enum logic [2:0] {
    STINT_AT_IDLE = 3'b001,
    STINT_AT_STILL = 3'b010,
    STINT_AT_MOVE = 3'b100
  } stint_at_state_t;

endpackage : stint_pkg

// File: verilog/stint_top.sv
// step pulse interpolator, standstill detection and tuning sequencer
// assumes step and direction pins are asynchronous, regulator feedback is on pclk
`timescale 1ns/100ps
`include "stint_defines.svh"

module stint_top #(
  parameter int MOTORS = 2,
  parameter int PERIOD_MAX = `STINT_PERIOD_MAX,
  parameter int AT1_CYCLES = `STINT_AT1_CLKS
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // step and direction pins
  input wire logic [MOTORS-1:0] step_pulse_input,
  input wire logic [MOTORS-1:0] direction_input,
  input wire logic supply_ok,
  // regulator feedback and per-motor results
  input stint_pkg::stint_fb_t [MOTORS-1:0] reg_fb,
  output stint_pkg::stint_mout_t [MOTORS-1:0] motor_out
);

  localparam int PW = $clog2(PERIOD_MAX) + 1;
  localparam int AW = $clog2(AT1_CYCLES + 1);

  // registers
  logic [31:0] driver_conf_r;
  logic [31:0] chop_conf_r;
  logic [31:0] current_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  // synchronisers
  logic [MOTORS-1:0] step_s1_r;
  logic [MOTORS-1:0] step_s2_r;
  logic [MOTORS-1:0] step_s3_r;
  logic [MOTORS-1:0] dir_s1_r;
  logic [MOTORS-1:0] dir_s2_r;
  logic sup_s1_r;
  logic sup_s2_r;
  // interpolator state
  logic [PW-1:0] period_cnt_r [MOTORS];
  logic [PW-1:0] spacing_r [MOTORS];
  logic [PW-1:0] gap_r [MOTORS];
  logic [8:0] remain_r [MOTORS];
  logic [8:0] step_amt_r [MOTORS];
  logic [9:0] pos_r [MOTORS];
  logic [MOTORS-1:0] pulse_r;
  logic [MOTORS-1:0] stst_r;
  logic [4:0] cs_r [MOTORS];
  // tuning state
  stint_pkg::stint_at_state_t state_r [MOTORS];
  logic [AW-1:0] at1_cnt_r [MOTORS];
  logic [11:0] acc_r [MOTORS];
  logic [7:0] ofs_r [MOTORS];
  logic [7:0] grad_r [MOTORS];
  logic [MOTORS-1:0] valid_r;
  // combinational
  logic [MOTORS-1:0] act_edge;
  logic [MOTORS-1:0] at1_cond;
  logic [MOTORS-1:0] at2_cond;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] status_w;
  logic [31:0] tune_w;

  // config decode
  logic intpol;
  logic dedge;
  logic at_en;
  logic hold_en;
  logic [4:0] hold_cur;
  logic [4:0] run_cur;
  logic [3:0] shift;
  logic [8:0] width_w;
  logic [5:0] idx;
  logic wr_en;
  logic rd_first;
  logic preset_wr;
  logic inval;

  // log2 of microsteps per pulse, settings above 8 clamp at one microstep
  function automatic logic [3:0] step_shift(input logic [3:0] mres);
    step_shift = (mres > `STINT_MSTEP_SHIFT_MAX) ? 4'h0 : `STINT_MSTEP_SHIFT_MAX - mres;
  endfunction : step_shift

  // microstep spacing, never below one cycle
  function automatic logic [PW-1:0] sp_calc(input logic [PW-1:0] per, input logic [3:0] sh);
    logic [PW-1:0] t;
    t = per >> sh;
    sp_calc = (t == '0) ? PW'(1) : t;
  endfunction : sp_calc

  // standstill timeout, longest option equals the measurable period
  function automatic logic [PW-1:0] tmo_of(input logic [2:0] sel);
    tmo_of = PW'(PERIOD_MAX) >> (3'h7 - sel);
  endfunction : tmo_of

  // signed position change for a step of w microsteps
  function automatic logic [9:0] dstep(input logic dir, input logic [8:0] w);
    dstep = dir ? (10'h000 - {1'b0, w}) : {1'b0, w};
  endfunction : dstep

  // gradient window: 1.5*p < sum/4 < 4*p with p = ofs*(run+1)/32
  function automatic logic win_ok(input logic [9:0] sum, input logic [7:0] ofs,
                                  input logic [4:0] lvl);
    logic [15:0] prod;
    prod = 16'(ofs) * 16'({1'b0, lvl} + 6'h01);
    win_ok = ({2'h0, sum, 4'h0} > 16'(prod * 16'h0003)) && ({5'h00, sum, 1'b0} < prod)
             && (sum < 10'h3FF);
  endfunction : win_ok

  assign intpol = chop_conf_r[`STINT_CHOP_INTPOL];
  assign dedge = chop_conf_r[`STINT_CHOP_DEDGE];
  assign at_en = chop_conf_r[`STINT_CHOP_AT_EN];
  assign hold_en = chop_conf_r[`STINT_CHOP_HOLD_EN];
  assign hold_cur = current_r[`STINT_CUR_HOLD_LSB +: 5];
  assign run_cur = current_r[`STINT_CUR_RUN_LSB +: 5];
  assign shift = step_shift(chop_conf_r[`STINT_CHOP_MRES_LSB +: 4]);
  assign width_w = 9'(9'h001 << shift);

  // apb strobes: one wait state, writes land where pready is sampled high
  assign idx = paddr[7:2];
  assign rd_first = psel & penable & ~pready_r;
  assign wr_en = psel & penable & pwrite & pready_r & rd_hit;
  assign preset_wr = wr_en && (idx == `STINT_IDX_PRESET);
  // range or gscale edits or a supply drop spoil the tuned values
  assign inval = ~sup_s2_r | (wr_en && (idx == `STINT_IDX_DRIVER_CONF) &&
                 ((pwdata[`STINT_DRV_RANGE_LSB +: `STINT_DRV_RANGE_W]
                   != driver_conf_r[`STINT_DRV_RANGE_LSB +: `STINT_DRV_RANGE_W])
                  || (pwdata[`STINT_DRV_GSCALE_LSB +: 8]
                      != driver_conf_r[`STINT_DRV_GSCALE_LSB +: 8])));

  // pins pass two flops, the third stage only feeds edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_s1_r <= '0;
      step_s2_r <= '0;
      step_s3_r <= '0;
      dir_s1_r <= '0;
      dir_s2_r <= '0;
      sup_s1_r <= 1'b0;
      sup_s2_r <= 1'b0;
    end else begin
      step_s1_r <= step_pulse_input;
      step_s2_r <= step_s1_r;
      step_s3_r <= step_s2_r;
      dir_s1_r <= direction_input;
      dir_s2_r <= dir_s1_r;
      sup_s1_r <= supply_ok;
      sup_s2_r <= sup_s1_r;
    end
  end

  // per-motor active edges and tuning conditions
  always_comb begin
    for (int m = 0; m < MOTORS; m++) begin
      act_edge[m] = dedge ? (step_s2_r[m] ^ step_s3_r[m]) : (step_s2_r[m] & ~step_s3_r[m]);
      at1_cond[m] = at_en & stst_r[m] & (cs_r[m] == run_cur) & sup_s2_r;
      at2_cond[m] = at_en & ~stst_r[m] & (cs_r[m] == run_cur) & sup_s2_r & valid_r[m]
                    & win_ok(reg_fb[m].summed_pwm_scale, ofs_r[m], run_cur);
    end
  end

  // period measurement, saturating so slow steps stay bounded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int m = 0; m < MOTORS; m++) begin
        period_cnt_r[m] <= '0;
        spacing_r[m] <= '0;
      end
    end else begin
      for (int m = 0; m < MOTORS; m++) begin
        if (act_edge[m]) begin
          period_cnt_r[m] <= PW'(1);
          spacing_r[m] <= sp_calc(period_cnt_r[m], shift);
        end else if (period_cnt_r[m] < PW'(PERIOD_MAX)) begin
          period_cnt_r[m] <= period_cnt_r[m] + PW'(1);
        end
      end
    end
  end

  // microstep scheduler; a new edge drops what the last one left unissued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_r <= '0;
      for (int m = 0; m < MOTORS; m++) begin
        gap_r[m] <= '0;
        remain_r[m] <= '0;
        step_amt_r[m] <= '0;
        pos_r[m] <= '0;
      end
    end else begin
      for (int m = 0; m < MOTORS; m++) begin
        pulse_r[m] <= 1'b0;
        if (act_edge[m]) begin
          pulse_r[m] <= 1'b1;
          gap_r[m] <= PW'(1);
          if (intpol) begin
            pos_r[m] <= pos_r[m] + dstep(dir_s2_r[m], 9'h001);
            remain_r[m] <= width_w - 9'h001;
            step_amt_r[m] <= 9'h001;
          end else begin
            pos_r[m] <= pos_r[m] + dstep(dir_s2_r[m], width_w);
            remain_r[m] <= '0;
            step_amt_r[m] <= width_w;
          end
        end else if (remain_r[m] != 9'h000) begin
          if (gap_r[m] >= spacing_r[m]) begin
            pulse_r[m] <= 1'b1;
            pos_r[m] <= pos_r[m] + dstep(dir_s2_r[m], 9'h001);
            remain_r[m] <= remain_r[m] - 9'h001;
            step_amt_r[m] <= 9'h001;
            gap_r[m] <= PW'(1);
          end else begin
            gap_r[m] <= gap_r[m] + PW'(1);
          end
        end
      end
    end
  end

  // standstill flag and current scale; the edge clear wins over the timeout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stst_r <= '0;
      for (int m = 0; m < MOTORS; m++) begin
        cs_r[m] <= '0;
      end
    end else begin
      for (int m = 0; m < MOTORS; m++) begin
        if (act_edge[m]) begin
          stst_r[m] <= 1'b0;
        end else if (period_cnt_r[m] >= tmo_of(driver_conf_r[`STINT_DRV_TMO_LSB
                     + m * `STINT_DRV_TMO_STRIDE +: 3])) begin
          stst_r[m] <= 1'b1;
        end
        cs_r[m] <= (stst_r[m] && hold_en) ? hold_cur : run_cur;
      end
    end
  end

  // tuning sequencer; a completing standstill phase sets valid even against a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_r <= '0;
      for (int m = 0; m < MOTORS; m++) begin
        state_r[m] <= stint_pkg::STINT_AT_IDLE;
        at1_cnt_r[m] <= '0;
        acc_r[m] <= '0;
        ofs_r[m] <= '0;
        grad_r[m] <= '0;
      end
    end else begin
      for (int m = 0; m < MOTORS; m++) begin
        if (inval) begin
          valid_r[m] <= 1'b0;
        end
        case (state_r[m])
          stint_pkg::STINT_AT_IDLE: begin
            if (!inval && at1_cond[m]) begin
              state_r[m] <= stint_pkg::STINT_AT_STILL;
              at1_cnt_r[m] <= '0;
            end else if (!inval && at2_cond[m]) begin
              state_r[m] <= stint_pkg::STINT_AT_MOVE;
              acc_r[m] <= '0;
            end
          end
          stint_pkg::STINT_AT_STILL: begin
            if (at1_cond[m] && at1_cnt_r[m] == AW'(AT1_CYCLES - 1)) begin
              ofs_r[m] <= reg_fb[m].summed_pwm_scale[9:2];
              valid_r[m] <= 1'b1;
              state_r[m] <= stint_pkg::STINT_AT_IDLE;
            end else if (!at1_cond[m] || inval) begin
              state_r[m] <= stint_pkg::STINT_AT_IDLE;
            end else begin
              at1_cnt_r[m] <= at1_cnt_r[m] + AW'(1);
            end
          end
          stint_pkg::STINT_AT_MOVE: begin
            if (!at2_cond[m] || inval) begin
              state_r[m] <= stint_pkg::STINT_AT_IDLE;
            end else if (pulse_r[m]) begin
              if (acc_r[m] + {3'h0, step_amt_r[m]} >= `STINT_AT2_MSTEPS) begin
                acc_r[m] <= acc_r[m] + {3'h0, step_amt_r[m]} - `STINT_AT2_MSTEPS;
                if (reg_fb[m].correction_up && grad_r[m] != 8'hFF) begin
                  grad_r[m] <= grad_r[m] + 8'h01;
                end else if (reg_fb[m].correction_down && grad_r[m] != 8'h00) begin
                  grad_r[m] <= grad_r[m] - 8'h01;
                end
              end else begin
                acc_r[m] <= acc_r[m] + {3'h0, step_amt_r[m]};
              end
            end
          end
          default: begin
            state_r[m] <= stint_pkg::STINT_AT_IDLE;
          end
        endcase
        // software preload overrides the adaptation for this cycle
        if (preset_wr) begin
          ofs_r[m] <= pwdata[16 * m +: 8];
          grad_r[m] <= pwdata[16 * m + 8 +: 8];
        end
      end
    end
  end

  // status and tuning read words
  always_comb begin
    status_w = '0;
    tune_w = '0;
    for (int m = 0; m < MOTORS; m++) begin
      status_w[m] = stst_r[m];
      status_w[4 + m] = valid_r[m];
      status_w[8 + 4 * m +: 3] = state_r[m];
      tune_w[16 * m +: 8] = ofs_r[m];
      tune_w[16 * m + 8 +: 8] = grad_r[m];
    end
  end

  // address decode; misaligned or unmapped words answer with an error
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      rd_hit = 1'b0;
    end else if (idx == `STINT_IDX_DRIVER_CONF) begin
      rd_data = driver_conf_r;
    end else if (idx == `STINT_IDX_CHOP_CONF) begin
      rd_data = chop_conf_r;
    end else if (idx == `STINT_IDX_CURRENT) begin
      rd_data = current_r;
    end else if (idx == `STINT_IDX_STATUS) begin
      rd_data = status_w;
    end else if (idx == `STINT_IDX_TUNE || idx == `STINT_IDX_PRESET) begin
      rd_data = tune_w;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // apb answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      pready_r <= rd_first;
      pslverr_r <= rd_first & ~rd_hit;
      if (rd_first && !pwrite) begin
        prdata_r <= rd_data;
      end
    end
  end

  // writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      driver_conf_r <= `STINT_DRIVER_CONF_RST;
      chop_conf_r <= `STINT_CHOP_CONF_RST;
      current_r <= `STINT_CURRENT_RST;
    end else if (wr_en) begin
      if (idx == `STINT_IDX_DRIVER_CONF) begin
        driver_conf_r <= pwdata;
      end else if (idx == `STINT_IDX_CHOP_CONF) begin
        chop_conf_r <= pwdata;
      end else if (idx == `STINT_IDX_CURRENT) begin
        current_r <= pwdata;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // outputs are wires from flops only
  always_comb begin
    for (int m = 0; m < MOTORS; m++) begin
      motor_out[m].mstep_pos = pos_r[m];
      motor_out[m].mstep_pulse = pulse_r[m];
      motor_out[m].standstill = stst_r[m];
      motor_out[m].current_scale = cs_r[m];
      motor_out[m].tuned_pwm_offset = ofs_r[m];
      motor_out[m].tuned_pwm_gradient = grad_r[m];
      motor_out[m].tune_valid = valid_r[m];
    end
  end

  // per-motor checks
  for (genvar g = 0; g < MOTORS; g++) begin : g_chk
    property p_burst;
      @(posedge pclk) disable iff (!presetn)
      (act_edge[g] && intpol) |=> (pulse_r[g] && remain_r[g] == $past(width_w) - 9'h001);
    endproperty
    a_burst: assert property (p_burst) else $error("no interpolated burst");
    property p_gap;
      @(posedge pclk) disable iff (!presetn)
      (remain_r[g] != 9'h000) |-> (gap_r[g] <= spacing_r[g]);
    endproperty
    a_gap: assert property (p_gap) else $error("microstep gap overrun");
    property p_plain;
      @(posedge pclk) disable iff (!presetn)
      (act_edge[g] && !intpol) |=> (remain_r[g] == 9'h000 && step_amt_r[g] == $past(width_w));
    endproperty
    a_plain: assert property (p_plain) else $error("plain step wrong");
    property p_cap;
      @(posedge pclk) disable iff (!presetn)
      period_cnt_r[g] <= PW'(PERIOD_MAX);
    endproperty
    a_cap: assert property (p_cap) else $error("period above cap");
    property p_stst_set;
      @(posedge pclk) disable iff (!presetn)
      (!act_edge[g] && period_cnt_r[g] >= tmo_of(driver_conf_r[g * 4 +: 3])) |=> stst_r[g];
    endproperty
    a_stst_set: assert property (p_stst_set) else $error("standstill missed");
    property p_stst_clr;
      @(posedge pclk) disable iff (!presetn)
      act_edge[g] |=> !stst_r[g] ##1 (cs_r[g] == $past(run_cur));
    endproperty
    a_stst_clr: assert property (p_stst_clr) else $error("standstill not cleared");
    property p_hold;
      @(posedge pclk) disable iff (!presetn)
      (stst_r[g] && hold_en) |=> (cs_r[g] == $past(hold_cur));
    endproperty
    a_hold: assert property (p_hold) else $error("hold current not applied");
    property p_at1;
      @(posedge pclk) disable iff (!presetn)
      (state_r[g] == stint_pkg::STINT_AT_STILL) |-> ($past(at1_cond[g])
        && at1_cnt_r[g] < AW'(AT1_CYCLES));
    endproperty
    a_at1: assert property (p_at1) else $error("offset tuning out of bounds");
    property p_grad;
      @(posedge pclk) disable iff (!presetn)
      ($changed(grad_r[g]) && !$past(preset_wr)) |-> ($past(at2_cond[g])
        && (grad_r[g] - $past(grad_r[g]) == 8'h01 || $past(grad_r[g]) - grad_r[g] == 8'h01));
    endproperty
    a_grad: assert property (p_grad) else $error("gradient step wrong");
    c_interp: cover property (@(posedge pclk) disable iff (!presetn)
      (act_edge[g] && intpol) ##1 (remain_r[g] != 9'h000) ##[1:300] pulse_r[g]);
    c_stst: cover property (@(posedge pclk) disable iff (!presetn) $rose(stst_r[g]));
    c_at1: cover property (@(posedge pclk) disable iff (!presetn) $rose(valid_r[g]));
    c_grad: cover property (@(posedge pclk) disable iff (!presetn)
      $changed(grad_r[g]) && !$past(preset_wr));
  end

endmodule : stint_top

// File: bench/stint_step_ctl.sv
// partner model: external motion controller on the step and direction pins
// assumes one pclk domain; the pins feed the synchronisers of the design
`timescale 1ns/100ps
module stint_step_ctl (
  // clock
  input wire logic pclk,
  // step and direction pins
  output logic [1:0] step_pulse_input = 2'h0,
  output logic [1:0] direction_input = 2'h0
);
  // pins idle low from their initialisers, so the task is the only driver
  // one pulse per masked motor, steady period, even duty for double edge
  task pulse(input logic [1:0] m, input logic d, input int gap);
    direction_input <= {2{d}}; // a cycle ahead, so no race with the edge
    @(posedge pclk);
    step_pulse_input <= m;
    repeat (gap / 2) @(posedge pclk);
    step_pulse_input <= 2'h0;
    repeat (gap / 2 - 1) @(posedge pclk);
  endtask : pulse
endmodule : stint_step_ctl

// File: bench/stint_top_tb.sv
// self-checking bench: apb register tasks and step bursts from the partner
// assumes counts shortened to PERIOD_MAX 256 and AT1_CYCLES 64
`timescale 1ns/100ps
module stint_top_tb;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, supply_ok, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] stp, dir;
  stint_pkg::stint_fb_t [1:0] reg_fb;
  stint_pkg::stint_mout_t [1:0] motor_out;
  int num_errors = 0;
  int total_checks = 0;
  int cnt = 0;
  int n;

  // 200 MHz
  always #2.5 pclk = ~pclk;

  stint_top #(.MOTORS(2), .PERIOD_MAX(256), .AT1_CYCLES(64)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .step_pulse_input(stp), .direction_input(dir), .supply_ok(supply_ok),
    .reg_fb(reg_fb), .motor_out(motor_out));
  stint_step_ctl ctl (.pclk(pclk), .step_pulse_input(stp), .direction_input(dir));

  // microsteps issued on motor 0
  always @(posedge pclk) if (motor_out[0].mstep_pulse === 1'h1) cnt <= cnt + 1;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
           input logic er);
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    chk({31'h0, pready}, 32'h1);
    if (!w) chk(prdata, e);
    chk({31'h0, pslverr}, {31'h0, er});
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // ten pulses on motor 0; the first two settle the measured interval
  task burst(input logic d, input logic [31:0] ec, input logic [9:0] ed);
    int c0;
    logic [9:0] p0, dp;
    ctl.pulse(2'h1, d, 72);
    ctl.pulse(2'h1, d, 72);
    c0 = cnt;
    p0 = motor_out[0].mstep_pos;
    repeat (8) ctl.pulse(2'h1, d, 72);
    repeat (100) @(posedge pclk);
    dp = motor_out[0].mstep_pos - p0;
    chk(cnt - c0, ec);
    chk({22'h0, dp}, {22'h0, ed});
  endtask : burst

  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // hang guard, well above the ~6k cycles of the sequence
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // main sequence
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    supply_ok = 1'h1;
    reg_fb = {2{10'h0C8, 2'h0}};
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    apb(1'h0, 8'h14, 32'h0, 32'h00000077, 1'h0);
    apb(1'h0, 8'h18, 32'h0, 32'h00000000, 1'h0);
    apb(1'h0, 8'h1C, 32'h0, 32'h00001F08, 1'h0);
    apb(1'h0, 8'h20, 32'h0, 32'h00001100, 1'h0);
    apb(1'h0, 8'h00, 32'h0, 32'h00000000, 1'h1);
    apb(1'h0, 8'h15, 32'h0, 32'h00000000, 1'h1);
    // preload offset 5 and gradient 7 on both motors; the preset word reads back as tune
    apb(1'h1, 8'h28, 32'h07050705, 32'h0, 1'h0);
    apb(1'h0, 8'h28, 32'h0, 32'h07050705, 1'h0);
    chk({24'h0, motor_out[1].tuned_pwm_offset}, 32'h05);
    apb(1'h1, 8'h14, 32'h00000037, 32'h0, 1'h0);
    apb(1'h1, 8'h18, 32'h00000241, 32'h0, 1'h0);
    // motor 1 times out after 16 cycles, motor 0 after 256
    ctl.pulse(2'h3, 1'h0, 40);
    chk({31'h0, motor_out[1].standstill}, 32'h1);
    chk({31'h0, motor_out[0].standstill}, 32'h0);
    repeat (260) @(posedge pclk);
    chk({31'h0, motor_out[0].standstill}, 32'h1);
    chk({27'h0, motor_out[0].current_scale}, 32'h8);
    ctl.pulse(2'h1, 1'h0, 72);
    chk({31'h0, motor_out[0].standstill}, 32'h0);
    chk({27'h0, motor_out[0].current_scale}, 32'h1F);
    burst(1'h0, 32'h80, 10'h080);
    burst(1'h1, 32'h80, 10'h380);
    apb(1'h1, 8'h18, 32'h00000240, 32'h0, 1'h0);
    burst(1'h0, 32'h08, 10'h080);
    apb(1'h1, 8'h18, 32'h00000242, 32'h0, 1'h0);
    burst(1'h0, 32'h10, 10'h100);
    // standstill tuning with hold equal to run
    apb(1'h1, 8'h1C, 32'h00001F1F, 32'h0, 1'h0);
    apb(1'h1, 8'h18, 32'h00000100, 32'h0, 1'h0);
    n = 0;
    while (motor_out[0].standstill !== 1'h1 && n < 400) begin
      n++;
      @(posedge pclk);
    end
    chk({31'h0, motor_out[0].standstill}, 32'h1);
    repeat (70) @(posedge pclk);
    chk({31'h0, motor_out[0].tune_valid}, 32'h1);
    apb(1'h0, 8'h24, 32'h0, 32'h07320732, 1'h0);
    chk({24'h0, motor_out[0].tuned_pwm_offset}, 32'h32);
    apb(1'h1, 8'h14, 32'h00000137, 32'h0, 1'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, motor_out[0].tune_valid}, 32'h0);
    repeat (70) @(posedge pclk);
    chk({31'h0, motor_out[0].tune_valid}, 32'h1);
    // motion tuning: scale outside then inside the window, 11 full steps each
    // plain full steps 100 cycles apart stay under the 256-cycle standstill timeout
    apb(1'h1, 8'h18, 32'h00000100, 32'h0, 1'h0);
    for (int i = 0; i < 2; i++) begin
      reg_fb <= {2{(i == 0) ? 10'h0C8 : 10'h190, 2'h2}};
      repeat (11) ctl.pulse(2'h1, 1'h0, 100);
      chk({24'h0, motor_out[0].tuned_pwm_gradient}, 32'h7 + i);
    end
    test_done();
  end
endmodule : stint_top_tb
